// *** hdl/serial_ir_config_regs.sv ***
// Configuration registers for two serial ports and the infrared option logic.
// Assumes an AXI4-Lite master on mclk and UART cores downstream of the mode outputs.
//
// Operation
// - Mode bit 0 of each serial port enables MIDI support; resets cleared.
// - Mode bit 1 of each serial port enables high speed; resets cleared.
// - First port mode bit 7 selects a shared common interrupt.
// - With sharing set, either port's interrupt asserts both assigned lines.
// - Infrared bit 0: receive polarity, zero active high, default zero.
// - Infrared bit 1: transmit polarity, one active low, default one.
// - Infrared bit 2: half duplex blanks reception around transmission.
// - Infrared bits 5:3 select standard, IrDA or amplitude-shift mode.
// - Infrared bit 6 routes the transmit output to the alternate infrared pin instead of port two.
// - Timeout register extends blanking 0 to 25.5 ms in 100 us steps, reset 3.
// - Timeout zero blanks only during activity; each unit adds one step.
// - Registers reset only on power-on or hard reset, not soft reset.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module serial_ir_config_regs
  import serial_ir_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        softReset,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        portOneIrq,
  input  wire logic        portTwoIrq,
  input  wire logic        portOneIrqAssigned,
  input  wire logic        portTwoIrqAssigned,
  input  wire logic        irTxActive,
  input  wire logic        irRxActive,
  input  wire logic        irRxRaw,
  input  wire logic        irTxRaw,
  output logic             portOneIrqLine,
  output logic             portTwoIrqLine,
  output logic             portOneMidi,
  output logic             portTwoMidi,
  output logic             portOneHighSpeed,
  output logic             portTwoHighSpeed,
  output logic [2:0]       irMode,
  output logic             amplitude_shift_infrared_mode,
  output logic             irRxData,
  output logic             second_port_transmit_pin,
  output logic             alt_infrared_transmit_pin,
  output logic             irRxBlank
);

  import serial_ir_pkg::*;

  typedef enum logic [1:0] {W_IDLE, W_RESP} wstate_t;

  logic [7:0]  mode1_q;
  logic [7:0]  mode2_q;
  logic [7:0]  irOpt_q;
  logic [7:0]  timeout_q;
  logic [7:0]  ctrl_q;
  wstate_t     wState_q;
  logic        awHave_q;
  logic        wHave_q;
  logic [11:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        blankNow;
  logic        irActive;
  logic        txLevel;
  logic        rxLevel;
  logic        rxPinSel;
  logic        anyIrq;
  logic        rxBlanked;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
                                       input logic [7:0] mask, input logic en);
    merge = en ? ((old & ~mask) | (val & mask)) : old;
  endfunction

  function automatic logic [31:0] read_word(input logic [11:0] a, input logic [7:0] m1,
                                            input logic [7:0] m2, input logic [7:0] io,
                                            input logic [7:0] t, input logic [7:0] c,
                                            input logic b);
    case (a)
      ADDR_MODE1:  read_word = {24'h000000, m1};
      ADDR_MODE2:  read_word = {24'h000000, m2};
      ADDR_IROPT:  read_word = {24'h000000, io};
      ADDR_TMO:    read_word = {24'h000000, t};
      ADDR_CTRL:   read_word = {24'h000000, c};
      ADDR_STATUS: read_word = {31'h00000000, b};
      default:     read_word = 32'h00000000;
    endcase
  endfunction

  function automatic logic known(input logic [11:0] a);
    known = (a == ADDR_MODE1) || (a == ADDR_MODE2) || (a == ADDR_IROPT) ||
            (a == ADDR_TMO) || (a == ADDR_STATUS) || (a == ADDR_CTRL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are latched independently, in either order.

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wState_q      <= W_IDLE;
      awHave_q      <= 1'b0;
      wHave_q       <= 1'b0;
      awAddr_q      <= 12'h000;
      wData_q       <= 32'h00000000;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      case (wState_q)
        W_IDLE: begin
          if (s_axi_awvalid && !awHave_q && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
          end
          if (s_axi_wvalid && !wHave_q && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
          end
          if (s_axi_awvalid && s_axi_awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= {s_axi_awaddr[11:2], 2'h0};
          end
          if (s_axi_wvalid && s_axi_wready) begin
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
          end
          if (awHave_q && wHave_q) begin
            awHave_q     <= 1'b0;
            wHave_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
            wState_q     <= W_RESP;
          end
        end
        W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wState_q     <= W_IDLE;
          end
        end
        default: wState_q <= W_IDLE;
      endcase
    end
  end

  wire doWrite = (wState_q == W_IDLE) && awHave_q && wHave_q && wStrb_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers. Only arst_n touches them; softReset is deliberately ignored
  // here so that a soft reset of the UARTs leaves the configuration intact.
  // Reserved bits are masked on write so they always read zero.

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode1_q <= MODE1_RST;
    end else if (doWrite) begin
      mode1_q <= merge(mode1_q, wData_q[7:0], MODE1_WMASK, awAddr_q == ADDR_MODE1);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode2_q <= MODE2_RST;
    end else if (doWrite) begin
      mode2_q <= merge(mode2_q, wData_q[7:0], MODE2_WMASK, awAddr_q == ADDR_MODE2);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irOpt_q <= IROPT_RST;
    end else if (doWrite) begin
      irOpt_q <= merge(irOpt_q, wData_q[7:0], IROPT_WMASK, awAddr_q == ADDR_IROPT);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timeout_q <= TMO_RST;
    end else if (doWrite) begin
      timeout_q <= merge(timeout_q, wData_q[7:0], 8'hFF, awAddr_q == ADDR_TMO);
    end
  end

  // The scratch byte keeps only bit 0, so software can probe the device-select split.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= 8'h00;
    end else if (doWrite) begin
      ctrl_q <= merge(ctrl_q, wData_q[7:0], 8'h01, awAddr_q == ADDR_CTRL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one-cycle ready, data one cycle later.

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= read_word({s_axi_araddr[11:2], 2'h0}, mode1_q, mode2_q, irOpt_q,
                                  timeout_q, ctrl_q, irRxBlank);
        s_axi_rresp  <= known({s_axi_araddr[11:2], 2'h0}) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt routing. Software follows the assign-one-then-share sequence;
  // with both lines assigned, sharing drives both lines from either source.
  // An unassigned port never drives its line, so the single-line sequence stays clean.

  assign anyIrq = portOneIrq | portTwoIrq;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      portOneIrqLine <= 1'b0;
    end else if (mode1_q[SHARE_BIT]) begin
      portOneIrqLine <= portOneIrqAssigned & anyIrq;
    end else begin
      portOneIrqLine <= portOneIrqAssigned & portOneIrq;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      portTwoIrqLine <= 1'b0;
    end else if (mode1_q[SHARE_BIT]) begin
      portTwoIrqLine <= portTwoIrqAssigned & anyIrq;
    end else begin
      portTwoIrqLine <= portTwoIrqAssigned & portTwoIrq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode outputs to the UART cores.

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      portOneMidi      <= 1'b0;
      portTwoMidi      <= 1'b0;
      portOneHighSpeed <= 1'b0;
      portTwoHighSpeed <= 1'b0;
    end else begin
      portOneMidi      <= mode1_q[MIDI_BIT];
      portTwoMidi      <= mode2_q[MIDI_BIT];
      portOneHighSpeed <= mode1_q[HS_BIT];
      portTwoHighSpeed <= mode2_q[HS_BIT];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irMode <= IRMODE_COM;
    end else begin
      // Reserved mode codes fall back to standard serial behaviour.
      case (irOpt_q[IRMODE_LSB +: 3])
        IRMODE_IRDA: irMode <= IRMODE_IRDA;
        IRMODE_ASK:  irMode <= IRMODE_ASK;
        default:     irMode <= IRMODE_COM;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      amplitude_shift_infrared_mode <= 1'b0;
    end else begin
      amplitude_shift_infrared_mode <= (irOpt_q[IRMODE_LSB +: 3] == IRMODE_ASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Infrared pin path: polarity, location and half-duplex blanking.

  assign irActive = irTxActive | irRxActive;
  assign rxPinSel = irOpt_q[IRLOC_BIT];
  assign rxLevel  = irRxRaw ^ irOpt_q[RXPOL_BIT];
  assign txLevel  = irTxRaw ^ irOpt_q[TXPOL_BIT];

  // Full duplex never blanks, whatever the timer holds.
  assign rxBlanked = irOpt_q[DUPLEX_BIT] & (blankNow | irTxActive);

  blank_timer blank_timer_inst (
    .mclk   (mclk),
    .arst_n (arst_n),
    .active (irActive),
    .units  (timeout_q),
    .blank  (blankNow)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irRxBlank <= 1'b0;
    end else begin
      irRxBlank <= rxBlanked;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irRxData <= 1'b0;
    end else begin
      irRxData <= rxBlanked ? 1'b0 : rxLevel;
    end
  end

  // The unselected transmit pin rests low, so only one pin ever carries data.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      second_port_transmit_pin  <= 1'b0;
      alt_infrared_transmit_pin <= 1'b0;
    end else begin
      second_port_transmit_pin  <= rxPinSel ? 1'b0 : txLevel;
      alt_infrared_transmit_pin <= rxPinSel ? txLevel : 1'b0;
    end
  end

endmodule

// *** hdl/serial_ir_pkg.sv ***
// Constants for the serial/infrared configuration register bank.
// Assumes a 100 MHz mclk and an AXI4-Lite register bus with 32-bit data.
package serial_ir_pkg;

  // Printed register indices (not byte addresses): byte address is index times four, plus the device-select bit.
  localparam logic [7:0] IDX_MODE    = 8'hF0;
  localparam logic [7:0] IDX_IROPT   = 8'hF1;
  localparam logic [7:0] IDX_TIMEOUT = 8'hF2;

  // Two logical devices share index 0xF0; a device-select bit in the address splits them.
  localparam int          DEV_BIT     = 10;
  localparam logic [11:0] ADDR_MODE1  = {2'h0, IDX_MODE, 2'h0};
  localparam logic [11:0] ADDR_MODE2  = {2'h1, IDX_MODE, 2'h0};
  localparam logic [11:0] ADDR_IROPT  = {2'h1, IDX_IROPT, 2'h0};
  localparam logic [11:0] ADDR_TMO    = {2'h1, IDX_TIMEOUT, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h1, 8'hF8, 2'h0};
  localparam logic [11:0] ADDR_CTRL   = {2'h1, 8'hF9, 2'h0};

  localparam logic [7:0] MODE1_RST   = 8'h00;
  localparam logic [7:0] MODE2_RST   = 8'h00;
  localparam logic [7:0] IROPT_RST   = 8'h02;
  localparam logic [7:0] TMO_RST     = 8'h03;
  localparam logic [7:0] MODE1_WMASK = 8'h83;
  localparam logic [7:0] MODE2_WMASK = 8'h03;
  localparam logic [7:0] IROPT_WMASK = 8'h7F;

  localparam int MIDI_BIT   = 0;
  localparam int HS_BIT     = 1;
  localparam int SHARE_BIT  = 7;
  localparam int RXPOL_BIT  = 0;
  localparam int TXPOL_BIT  = 1;
  localparam int DUPLEX_BIT = 2;
  localparam int IRMODE_LSB = 3;
  localparam int IRLOC_BIT  = 6;

  localparam logic [2:0] IRMODE_COM  = 3'h0;
  localparam logic [2:0] IRMODE_IRDA = 3'h1;
  localparam logic [2:0] IRMODE_ASK  = 3'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_HZ       = 100_000_000;
  localparam int STEP_US      = 100;
  localparam int STEP_CYCLES  = CLK_HZ / 1_000_000 * STEP_US;
  localparam logic [13:0] STEP_LAST = 14'(STEP_CYCLES - 1);

endpackage

// *** hdl/blank_timer.sv ***
// Half-duplex receive blanking timer for the infrared port.
// Assumes activity flags synchronous to mclk; tick count fixed by the package.
`timescale 1ns/1ps
module blank_timer
  import serial_ir_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       active,
  input  wire logic [7:0] units,
  output logic            blank
);

  logic [13:0] tickCnt_q;
  logic [7:0]  unitCnt_q;
  logic        hold_q;

  // Counting starts fresh at the end of each activity burst so every step is a full 100 us.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt_q <= 14'h0000;
      unitCnt_q <= 8'h00;
      hold_q    <= 1'b0;
    end else if (active) begin
      tickCnt_q <= 14'h0000;
      unitCnt_q <= units;
      hold_q    <= (units != 8'h00);
    end else if (hold_q) begin
      if (tickCnt_q == STEP_LAST) begin
        tickCnt_q <= 14'h0000;
        unitCnt_q <= unitCnt_q - 8'h01;
        if (unitCnt_q == 8'h01) begin
          hold_q <= 1'b0;
        end
      end else begin
        tickCnt_q <= tickCnt_q + 14'h0001;
      end
    end
  end

  assign blank = active | hold_q;

endmodule

// *** tb/serial_ir_config_regs_asserts.sv ***
// Port-level checker for the serial/infrared configuration register bank.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module serial_ir_config_regs_asserts (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        portOneIrq,
  input wire logic        portTwoIrq,
  input wire logic        portOneIrqAssigned,
  input wire logic        portTwoIrqAssigned,
  input wire logic        portOneIrqLine,
  input wire logic        portTwoIrqLine,
  input wire logic [2:0]  irMode,
  input wire logic        amplitude_shift_infrared_mode,
  input wire logic        irRxData,
  input wire logic        irRxBlank,
  input wire logic        second_port_transmit_pin,
  input wire logic        alt_infrared_transmit_pin,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  localparam logic [2:0] IRMODE_ASK_C = 3'h2;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  AST_IRQ_OWN: assert property (
    $past(arst_n) && portOneIrqAssigned && portOneIrq |=> portOneIrqLine)
    else $error("own interrupt did not reach its assigned line");
  AST_IRQ2_OWN: assert property (
    $past(arst_n) && portTwoIrqAssigned && portTwoIrq |=> portTwoIrqLine)
    else $error("port two interrupt did not reach its assigned line");
  AST_IRQ1_UNASSIGNED: assert property (
    $past(arst_n) && !portOneIrqAssigned |=> !portOneIrqLine)
    else $error("unassigned port one line asserted");
  AST_IRQ2_UNASSIGNED: assert property (
    $past(arst_n) && !portTwoIrqAssigned |=> !portTwoIrqLine)
    else $error("unassigned port two line asserted");
  AST_ASK_FLAG: assert property (
    amplitude_shift_infrared_mode == (irMode == IRMODE_ASK_C))
    else $error("amplitude shift flag disagrees with mode");
  AST_MODE_RANGE: assert property (irMode <= 3'h2)
    else $error("reserved infrared mode appeared");
  AST_TX_ONE_PIN: assert property (
    !(second_port_transmit_pin && alt_infrared_transmit_pin))
    else $error("both transmit pins driven");
  AST_RX_BLANKED: assert property (irRxBlank |-> !irRxData)
    else $error("receive data passed while blanked");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_RVALID_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed early");
  AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
endmodule

// *** tb/serial_ir_config_regs_tb.sv ***
// Self-checking bench for the serial/infrared configuration register bank.
// Assumes the design answers AXI4-Lite with registered handshakes on mclk.
`timescale 1ns/1ps
module serial_ir_config_regs_tb;
  import serial_ir_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] rsp;} row_t;
  logic mclk = 0, arst_n = 0, softReset = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic irq1 = 0, irq2 = 0, asg1 = 0, asg2 = 0, txAct = 0, rxAct = 0, rxRaw = 0, txRaw = 0;
  logic line1, line2, midi1, midi2, hs1, hs2, ask, rxData, txPin, altTx, blank;
  logic [2:0] mode;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  row_t rows [6] = '{'{ADDR_MODE1, 32'hFFFF_FFFF, 32'h83, RESP_OKAY},
                     '{ADDR_MODE2, 32'hFFFF_FFFF, 32'h03, RESP_OKAY},
                     '{ADDR_IROPT, 32'hFFFF_FFFF, 32'h7F, RESP_OKAY},
                     '{ADDR_TMO, 32'h0000_00A5, 32'hA5, RESP_OKAY},
                     '{12'h100, 32'hFFFF_FFFF, 32'h00, RESP_SLVERR},
                     '{ADDR_CTRL, 32'hFFFF_FFFF, 32'h01, RESP_OKAY}};
  serial_ir_config_regs serial_ir_config_regs_inst (.mclk(mclk), .arst_n(arst_n),
    .softReset(softReset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .portOneIrq(irq1), .portTwoIrq(irq2), .portOneIrqAssigned(asg1),
    .portTwoIrqAssigned(asg2), .irTxActive(txAct), .irRxActive(rxAct), .irRxRaw(rxRaw),
    .irTxRaw(txRaw), .portOneIrqLine(line1), .portTwoIrqLine(line2), .portOneMidi(midi1),
    .portTwoMidi(midi2), .portOneHighSpeed(hs1), .portTwoHighSpeed(hs2), .irMode(mode),
    .amplitude_shift_infrared_mode(ask), .irRxData(rxData),
    .second_port_transmit_pin(txPin), .alt_infrared_transmit_pin(altTx), .irRxBlank(blank));
  ////////////////////////////////////////////////////////////////////////////////
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    forever begin
      @(posedge mclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin
        rsp = bresp; bready <= 0; break;
      end
    end
  endtask
  task automatic rdr(input logic [11:0] a);
    @(posedge mclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    forever begin
      @(posedge mclk);
      if (arready) arvalid <= 0;
      if (rvalid) begin
        rd = rdata; rsp = rresp; rready <= 0; break;
      end
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [11:0] adr [4];
    logic [7:0] dflt [4];
    adr = '{ADDR_MODE1, ADDR_MODE2, ADDR_IROPT, ADDR_TMO};
    dflt = '{8'h00, 8'h00, 8'h02, 8'h03};
    repeat (8) @(posedge mclk);
    arst_n <= 1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      chk(rsp, rows[i].rsp, "write response");
      rdr(rows[i].a);
      chk(rd, rows[i].r, "readback");
      chk(rsp, rows[i].rsp, "read response");
    end
    settle();
    chk({midi1, hs1, midi2, hs2}, 4'hF, "mode outputs set");
    $display("table test done");
    wr(ADDR_MODE1, 32'h80); wr(ADDR_MODE2, 32'h00);
    @(posedge mclk); asg1 <= 1; asg2 <= 1; irq2 <= 1;
    settle();
    chk({midi1, hs1, midi2, hs2, line1, line2}, 6'h03, "shared interrupt");
    wr(ADDR_MODE1, 32'h00);
    settle();
    chk({line1, line2}, 2'h1, "separate interrupts");
    @(posedge mclk);
    asg2 <= 0;
    wr(ADDR_MODE1, 32'h80);
    settle();
    chk({line1, line2}, 2'h2, "single assigned line shared");
    @(posedge mclk);
    irq1 <= 1;
    irq2 <= 0;
    settle();
    chk({line1, line2}, 2'h2, "own interrupt on shared line");
    $display("interrupt test done");
    wstrb <= 4'h0;
    wr(ADDR_MODE2, 32'h03);
    chk(rsp, RESP_OKAY, "masked write response");
    wstrb <= 4'hF;
    rdr(ADDR_MODE2);
    chk(rd, 32'h00, "masked write ignored");
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_IROPT, 32'(m << 3));
      settle();
      chk({ask, mode}, (m == 2) ? 4'hA : ((m < 2) ? 4'(m) : 4'h0), "infrared mode");
    end
    @(posedge mclk); txRaw <= 1;
    wr(ADDR_IROPT, 32'h01);
    settle();
    chk({rxData, txPin, altTx}, 3'h6, "polarity and normal pins");
    wr(ADDR_IROPT, 32'h40);
    settle();
    chk({txPin, altTx}, 2'h1, "alternate pins");
    wr(ADDR_IROPT, 32'h02);
    settle();
    chk(txPin, 1'b0, "transmit active low");
    $display("infrared option test done");
    wr(ADDR_TMO, 32'h02); wr(ADDR_IROPT, 32'h04);
    @(posedge mclk); txAct <= 1;
    settle();
    chk(blank, 1'b1, "blank during transmit");
    rdr(ADDR_STATUS);
    chk(rd, 32'h01, "status shows blanking");
    @(posedge mclk); txAct <= 0;
    repeat (15000) @(posedge mclk);
    chk(blank, 1'b1, "blank extended");
    repeat (6000) @(posedge mclk);
    #1;
    chk(blank, 1'b0, "blank released");
    wr(ADDR_TMO, 32'h00);
    @(posedge mclk); rxAct <= 1;
    settle();
    chk(blank, 1'b1, "blank during receive");
    @(posedge mclk); rxAct <= 0;
    settle();
    chk(blank, 1'b0, "zero timeout");
    wr(ADDR_IROPT, 32'h00);
    @(posedge mclk); txAct <= 1;
    settle();
    chk(blank, 1'b0, "full duplex never blanks");
    $display("blanking test done");
    wr(ADDR_MODE1, 32'h81);
    @(posedge mclk); softReset <= 1;
    repeat (4) @(posedge mclk);
    softReset <= 0;
    rdr(ADDR_MODE1);
    chk(rd, 32'h81, "kept through soft reset");
    @(posedge mclk); arst_n <= 0;
    repeat (2) @(posedge mclk);
    arst_n <= 1;
    foreach (adr[i]) begin
      rdr(adr[i]);
      chk(rd, 32'(dflt[i]), "reset value");
    end
    $display("reset test done");
    report_and_stop();
  end
endmodule
bind serial_ir_config_regs serial_ir_config_regs_asserts serial_ir_config_regs_asserts_inst (
  .mclk(mclk), .arst_n(arst_n), .portOneIrq(portOneIrq), .portTwoIrq(portTwoIrq),
  .portOneIrqAssigned(portOneIrqAssigned), .portTwoIrqAssigned(portTwoIrqAssigned),
  .portOneIrqLine(portOneIrqLine), .portTwoIrqLine(portTwoIrqLine), .irMode(irMode),
  .amplitude_shift_infrared_mode(amplitude_shift_infrared_mode), .irRxData(irRxData),
  .irRxBlank(irRxBlank), .second_port_transmit_pin(second_port_transmit_pin),
  .alt_infrared_transmit_pin(alt_infrared_transmit_pin), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata));
